// ### pkg/mgs_consts.svh
// constants for the module general status register block
`ifndef MGS_CONSTS_SVH
`define MGS_CONSTS_SVH

// ==========================================================
// bus widths
`define MGS_APB_AW 18
`define MGS_IDX_W 16
`define MGS_REG_W 16

// ==========================================================
// register indices (byte address is four times the index)
`define MGS_IDX_STATUS 16'hb01d
`define MGS_IDX_LATCH 16'hb023
`define MGS_IDX_LANE_BASE 16'hb1a0
`define MGS_IDX_CTRL 16'hb400
`define MGS_IDX_COOL_CAP 16'hb401
`define MGS_IDX_ALARM_SEL 16'hb402

// ==========================================================
// general status field positions
`define MGS_BIT_COOLING 13
`define MGS_BIT_REFERENCE_CLOCK_INPUT 10
`define MGS_BIT_TX_PLL 9
`define MGS_BIT_TX_CMU 8
`define MGS_BIT_TX_SIGF 7
`define MGS_BIT_TX_HOST 6
`define MGS_BIT_RX_SIGNAL_LOSS 5
`define MGS_BIT_RX_NET 4
`define MGS_STATUS_MASK 16'h27f0

// ==========================================================
// per-lane word field positions
`define MGS_LANE_TX_SIGF 7
`define MGS_LANE_TX_LOCK 6
`define MGS_LANE_RX_SIGNAL_LOSS 4
`define MGS_LANE_RX_LOCK 3
`define MGS_MAX_LANES 16

// ==========================================================
// control register fields and reset values
`define MGS_CTRL_TX_EN 0
`define MGS_CTRL_ILOCK_USED 1
`define MGS_CTRL_REFERENCE_CLOCK_INPUT_EN 2
`define MGS_CTRL_PLL_EN 3
`define MGS_CTRL_CMU_EN 4
`define MGS_CTRL_MASK 16'h001f
`define MGS_CTRL_RESET 16'h001c
`define MGS_COOL_CAP_RESET 16'hffff
`define MGS_ALARM_SEL_RESET 16'h0000
`define MGS_ALARM_FIELD_W 3
`define MGS_ALARM_STRIDE 4
`define MGS_ALARM_PINS 3
`define MGS_ALARM_SRCS 5

`endif

// ### pkg/mgs_pkg.sv
// types shared by the module general status register block
`include "mgs_consts.svh"
package mgs_pkg;

  // ==========================================================
  // apb carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`MGS_APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } mgs_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mgs_apb_rsp_t;

  // ==========================================================
  // alarm pin source codes
  typedef enum logic [`MGS_ALARM_FIELD_W-1:0] {
    MGS_ALM_OFF,
    MGS_ALM_TX_HOST,
    MGS_ALM_RX_NET,
    MGS_ALM_TX_SIGF,
    MGS_ALM_COOL
  } mgs_alarm_src_t;

endpackage

// ### verilog/mgs_change_latch.sv
// one latch bit that records any change of a status level
`timescale 1ns/1ps
`default_nettype none

module mgs_change_latch (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic coreClkEn,
  input wire logic level,
  input wire logic clear,
  output logic flag
);
  logic prev_r;
  logic flag_r;
  logic change;

  assign change = level ^ prev_r;
  assign flag = flag_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else if (coreClkEn) begin
      prev_r <= level;
      // a change in the clearing cycle keeps the flag set
      flag_r <= change | (flag_r & ~clear);
    end
  end
endmodule // mgs_change_latch

`default_nettype wire

// ### verilog/mgs_alarm_mux.sv
// one programmable alarm pin with its source selector
`timescale 1ns/1ps
`default_nettype none
`include "mgs_consts.svh"

module mgs_alarm_mux (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic coreClkEn,
  input wire logic [`MGS_ALARM_FIELD_W-1:0] sel,
  input wire logic [`MGS_ALARM_SRCS-1:0] sources,
  output logic pin
);
  logic pin_r;
  logic pinNxt;
  logic selValid;

  assign selValid = (sel < `MGS_ALARM_FIELD_W'(`MGS_ALARM_SRCS));
  assign pinNxt = selValid ? sources[sel] : 1'b0;
  assign pin = pin_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_r <= 1'b0;
    end else if (coreClkEn) begin
      pin_r <= pinNxt;
    end
  end
endmodule // mgs_alarm_mux

`default_nettype wire

// ### verilog/mgs_general_status.sv
// module general status register, its change latch and the apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mgs_consts.svh"

module mgs_general_status #(
  parameter int NET_LANES = 16,
  parameter int HOST_LANES = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic coreClkEn,
  input wire mgs_pkg::mgs_apb_req_t apbReq,
  output mgs_pkg::mgs_apb_rsp_t apbRsp,
  input wire logic [NET_LANES-1:0][`MGS_REG_W-1:0] netLaneStatus,
  input wire logic [HOST_LANES-1:0] hostTxLockLoss,
  input wire logic refClkLoss,
  input wire logic txJitterPllUnlock,
  input wire logic txClockMultiplierUnlock,
  input wire logic [`MGS_REG_W-1:0] modulePower,
  output logic [`MGS_ALARM_PINS-1:0] alarmPins
);

  // ==========================================================
  // elaboration checks
  if (NET_LANES < 1 || NET_LANES > `MGS_MAX_LANES) begin : g_bad_lanes
    $error("NET_LANES must lie between 1 and 16");
  end
  if (HOST_LANES < 1) begin : g_bad_host
    $error("HOST_LANES must be at least 1");
  end

  // ==========================================================
  // state
  logic [`MGS_REG_W-1:0] status_r;
  logic [`MGS_REG_W-1:0] statusNxt;
  logic [`MGS_REG_W-1:0] ctrl_r;
  logic [`MGS_REG_W-1:0] coolCap_r;
  logic [`MGS_REG_W-1:0] alarmSel_r;
  mgs_pkg::mgs_apb_rsp_t rsp_r;
  logic [`MGS_REG_W-1:0] latchFlags;
  logic [`MGS_REG_W-1:0] latchClr;

  // ==========================================================
  // lane summaries
  logic [NET_LANES-1:0] laneTxSigf;
  logic [NET_LANES-1:0] laneRxLos;
  logic [NET_LANES-1:0] laneRxLock;

  for (genvar i = 0; i < NET_LANES; i++) begin : g_lane
    assign laneTxSigf[i] = netLaneStatus[i][`MGS_LANE_TX_SIGF];
    assign laneRxLos[i] = netLaneStatus[i][`MGS_LANE_RX_SIGNAL_LOSS];
    assign laneRxLock[i] = netLaneStatus[i][`MGS_LANE_RX_LOCK];
  end

  logic txEnable;
  logic interlockUsed;
  logic txSigfAny;
  logic txHostAny;
  logic rxLosAny;
  logic rxNetAny;
  logic coolingNxt;

  assign txEnable = ctrl_r[`MGS_CTRL_TX_EN];
  assign interlockUsed = ctrl_r[`MGS_CTRL_ILOCK_USED];
  // a disabled transmitter reports no functionality loss
  assign txSigfAny = (|laneTxSigf) & txEnable;
  assign txHostAny = |hostTxLockLoss;
  assign rxLosAny = |laneRxLos;
  assign rxNetAny = |laneRxLock;
  // compared against a software-set capacity, so no pin can force the flag
  assign coolingNxt = interlockUsed & (modulePower > coolCap_r);

  always_comb begin
    statusNxt = '0;
    statusNxt[`MGS_BIT_COOLING] = coolingNxt;
    statusNxt[`MGS_BIT_REFERENCE_CLOCK_INPUT] = refClkLoss & ctrl_r[`MGS_CTRL_REFERENCE_CLOCK_INPUT_EN];
    statusNxt[`MGS_BIT_TX_PLL] = txJitterPllUnlock & ctrl_r[`MGS_CTRL_PLL_EN];
    statusNxt[`MGS_BIT_TX_CMU] = txClockMultiplierUnlock & ctrl_r[`MGS_CTRL_CMU_EN];
    statusNxt[`MGS_BIT_TX_SIGF] = txSigfAny;
    statusNxt[`MGS_BIT_TX_HOST] = txHostAny;
    statusNxt[`MGS_BIT_RX_SIGNAL_LOSS] = rxLosAny;
    statusNxt[`MGS_BIT_RX_NET] = rxNetAny;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_r <= '0;
    end else if (coreClkEn) begin
      status_r <= statusNxt;
    end
  end

  // ==========================================================
  // apb decode
  logic [`MGS_IDX_W-1:0] regIdx;
  logic misaligned;
  logic selStatus;
  logic selLatch;
  logic selCtrl;
  logic selCoolCap;
  logic selAlarm;
  logic selLane;
  logic [3:0] laneIdx;
  logic [`MGS_IDX_W-1:0] laneOffset;
  logic mapped;
  logic setupPhase;
  logic accessDone;
  logic writeOk;
  logic latchRead;

  assign regIdx = apbReq.paddr[`MGS_APB_AW-1:2];
  assign misaligned = |apbReq.paddr[1:0];
  assign laneOffset = regIdx - `MGS_IDX_LANE_BASE;
  assign laneIdx = laneOffset[3:0];
  assign selStatus = (regIdx == `MGS_IDX_STATUS);
  assign selLatch = (regIdx == `MGS_IDX_LATCH);
  assign selCtrl = (regIdx == `MGS_IDX_CTRL);
  assign selCoolCap = (regIdx == `MGS_IDX_COOL_CAP);
  assign selAlarm = (regIdx == `MGS_IDX_ALARM_SEL);
  assign selLane = (regIdx >= `MGS_IDX_LANE_BASE) &&
                   (laneOffset < `MGS_IDX_W'(NET_LANES));
  assign mapped = !misaligned &&
                  (selStatus | selLatch | selCtrl | selCoolCap | selAlarm | selLane);
  assign setupPhase = apbReq.psel & ~apbReq.penable & ~rsp_r.pready;
  assign accessDone = apbReq.psel & apbReq.penable & rsp_r.pready;
  assign writeOk = accessDone & apbReq.pwrite & ~rsp_r.pslverr;
  assign latchRead = accessDone & ~apbReq.pwrite & ~rsp_r.pslverr & selLatch;

  // ==========================================================
  // read data
  logic [`MGS_REG_W-1:0] laneWord;
  logic [`MGS_REG_W-1:0] readWord;

  assign laneWord = selLane ? netLaneStatus[laneIdx] : '0;
  assign readWord = selStatus ? (status_r & `MGS_STATUS_MASK) :
                    selLatch ? (latchFlags & `MGS_STATUS_MASK) :
                    selCtrl ? ctrl_r :
                    selCoolCap ? coolCap_r :
                    selAlarm ? alarmSel_r :
                    laneWord;

  // only the bits that were returned are cleared, so a change that lands
  // between setup and access is still seen on the next read
  assign latchClr = latchRead ? rsp_r.prdata[`MGS_REG_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rsp_r <= '0;
    end else if (coreClkEn) begin
      rsp_r.pready <= setupPhase;
      rsp_r.pslverr <= setupPhase & ~mapped;
      rsp_r.prdata <= (setupPhase & ~apbReq.pwrite & mapped) ? {16'h0000, readWord} : 32'h0000_0000;
    end
  end

  assign apbRsp = rsp_r;

  // ==========================================================
  // writable registers; status, latch and lane words have no write path
  function automatic logic [`MGS_REG_W-1:0] merge16(
    input logic [`MGS_REG_W-1:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [`MGS_REG_W-1:0] res;
    res[7:0] = strb[0] ? wdata[7:0] : old[7:0];
    res[15:8] = strb[1] ? wdata[15:8] : old[15:8];
    return res;
  endfunction

  logic [`MGS_REG_W-1:0] ctrlNxt;
  logic [`MGS_REG_W-1:0] coolCapNxt;
  logic [`MGS_REG_W-1:0] alarmSelNxt;

  assign ctrlNxt = (writeOk & selCtrl) ?
                   (merge16(ctrl_r, apbReq.pwdata, apbReq.pstrb) & `MGS_CTRL_MASK) : ctrl_r;
  assign coolCapNxt = (writeOk & selCoolCap) ?
                      merge16(coolCap_r, apbReq.pwdata, apbReq.pstrb) : coolCap_r;
  assign alarmSelNxt = (writeOk & selAlarm) ?
                       (merge16(alarmSel_r, apbReq.pwdata, apbReq.pstrb) & 16'h0777) : alarmSel_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_r <= `MGS_CTRL_RESET;
      coolCap_r <= `MGS_COOL_CAP_RESET;
      alarmSel_r <= `MGS_ALARM_SEL_RESET;
    end else if (coreClkEn) begin
      ctrl_r <= ctrlNxt;
      coolCap_r <= coolCapNxt;
      alarmSel_r <= alarmSelNxt;
    end
  end

  // ==========================================================
  // change latches for every implemented status bit
  for (genvar b = 0; b < `MGS_REG_W; b++) begin : g_latch
    localparam logic [`MGS_REG_W-1:0] STATUS_MASK = `MGS_STATUS_MASK;
    if (STATUS_MASK[b]) begin : g_bit
      mgs_change_latch u_latch (
        .core_clk(core_clk),
        .resetn(resetn),
        .coreClkEn(coreClkEn),
        .level(status_r[b]),
        .clear(latchClr[b]),
        .flag(latchFlags[b])
      );
    end else begin : g_none
      assign latchFlags[b] = 1'b0;
    end
  end

  // ==========================================================
  // programmable alarm pins
  logic [`MGS_ALARM_SRCS-1:0] alarmSources;

  assign alarmSources[mgs_pkg::MGS_ALM_OFF] = 1'b0;
  assign alarmSources[mgs_pkg::MGS_ALM_TX_HOST] = status_r[`MGS_BIT_TX_HOST];
  assign alarmSources[mgs_pkg::MGS_ALM_RX_NET] = status_r[`MGS_BIT_RX_NET];
  assign alarmSources[mgs_pkg::MGS_ALM_TX_SIGF] = status_r[`MGS_BIT_TX_SIGF];
  assign alarmSources[mgs_pkg::MGS_ALM_COOL] = status_r[`MGS_BIT_COOLING];

  for (genvar p = 0; p < `MGS_ALARM_PINS; p++) begin : g_alarm
    mgs_alarm_mux u_mux (
      .core_clk(core_clk),
      .resetn(resetn),
      .coreClkEn(coreClkEn),
      .sel(alarmSel_r[p*`MGS_ALARM_STRIDE +: `MGS_ALARM_FIELD_W]),
      .sources(alarmSources),
      .pin(alarmPins[p])
    );
  end

  // ==========================================================
  // assertions
  logic [`MGS_REG_W-1:0] statusSeen_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      statusSeen_r <= '0;
    end else if (coreClkEn) begin
      statusSeen_r <= status_r;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_cooling_flag: assert property (
    coreClkEn |=> status_r[`MGS_BIT_COOLING] ==
                  $past(ctrl_r[`MGS_CTRL_ILOCK_USED] && (modulePower > coolCap_r)))
    else $error("cooling overload bit does not follow power against capacity");

  a_reference_clock_input_loss: assert property (
    coreClkEn |=> status_r[`MGS_BIT_REFERENCE_CLOCK_INPUT] ==
                  $past(refClkLoss & ctrl_r[`MGS_CTRL_REFERENCE_CLOCK_INPUT_EN]))
    else $error("reference clock loss bit wrong");

  a_pll_cmu_lock: assert property (
    coreClkEn |=> status_r[`MGS_BIT_TX_PLL +: 1] == $past(txJitterPllUnlock & ctrl_r[3]) &&
                  status_r[`MGS_BIT_TX_CMU] == $past(txClockMultiplierUnlock & ctrl_r[4]))
    else $error("pll or clock multiplier lock bit wrong");

  a_tx_sigf_or: assert property (
    coreClkEn |=> status_r[`MGS_BIT_TX_SIGF] == $past((|laneTxSigf) && txEnable))
    else $error("transmit functionality summary wrong");

  a_lock_los_or: assert property (
    coreClkEn |=> status_r[`MGS_BIT_TX_HOST] == $past(|hostTxLockLoss) &&
                  status_r[`MGS_BIT_RX_SIGNAL_LOSS] == $past(|laneRxLos) &&
                  status_r[`MGS_BIT_RX_NET] == $past(|laneRxLock))
    else $error("lock or signal loss summary wrong");

  a_change_latch: assert property (
    (coreClkEn && (status_r[7:4] != statusSeen_r[7:4])) |=>
      ((latchFlags[7:4] & $past(status_r[7:4] ^ statusSeen_r[7:4])) ==
       $past(status_r[7:4] ^ statusSeen_r[7:4])))
    else $error("status change did not set its latch bit");

  a_latch_hold: assert property (
    (latchClr == '0) |=> ((latchFlags & $past(latchFlags)) == $past(latchFlags)))
    else $error("latch bit dropped without a read");

  a_reserved_zero: assert property (
    (setupPhase && coreClkEn && !apbReq.pwrite && (selStatus || selLatch) && !misaligned) |=>
      rsp_r.pready && (rsp_r.prdata & ~{16'h0000, `MGS_STATUS_MASK}) == 32'h0000_0000)
    else $error("reserved status bits read nonzero");

  a_alarm_route: assert property (
    (coreClkEn && alarmSel_r[2:0] == mgs_pkg::MGS_ALM_TX_HOST) |=>
      alarmPins[0] == $past(status_r[`MGS_BIT_TX_HOST]))
    else $error("alarm pin zero does not follow the host lock summary");

  a_apb_answer: assert property (
    (setupPhase && coreClkEn) |=> rsp_r.pready ##1 !rsp_r.pready)
    else $error("apb answer not one cycle after setup");

  a_slverr_unmapped: assert property (
    (setupPhase && coreClkEn && !mapped) |=> rsp_r.pslverr && rsp_r.prdata == 32'h0000_0000)
    else $error("unmapped access answered without an error");

  a_lane_word: assert property (
    (setupPhase && coreClkEn && !apbReq.pwrite && selLane && !misaligned) |=>
      rsp_r.prdata == {16'h0000, $past(netLaneStatus[laneIdx])})
    else $error("lane word read back wrong");

  a_alarm_off: assert property (
    (coreClkEn && (alarmSel_r[6:4] == mgs_pkg::MGS_ALM_OFF || alarmSel_r[6:4] > 3'h4)) |=>
      !alarmPins[1])
    else $error("alarm pin one driven while its source is off");

  // pready stays high while the enable is low, so a master that finishes
  // its access then loses the write; hosts keep the enable high on the bus
  a_freeze_hold: assert property (
    !coreClkEn |=> status_r == $past(status_r) && latchFlags == $past(latchFlags) &&
                   ctrl_r == $past(ctrl_r) && rsp_r == $past(rsp_r))
    else $error("state moved while the clock enable was low");

  c_latch_read: cover property (latchRead && latchClr != '0);
  c_alarm_pin: cover property ($rose(alarmPins[0]));
  c_slverr: cover property (accessDone && rsp_r.pslverr);
  c_ctrl_write: cover property (writeOk && selCtrl);
  c_freeze: cover property (!coreClkEn && alarmPins != '0);

endmodule // mgs_general_status

`default_nettype wire

// ### verif/mgs_host_model.sv
// apb host model that issues single register transfers for the bench
`timescale 1ns/1ps
`default_nettype none
`include "mgs_consts.svh"

module mgs_host_model (
  input wire logic core_clk,
  output var mgs_pkg::mgs_apb_req_t apbReq,
  input wire mgs_pkg::mgs_apb_rsp_t apbRsp
);
  initial begin
    apbReq = '0;
  end

  // ==========================================================
  // one transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic timedOut);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
                pwdata: wdata, pstrb: 4'hf};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 64);
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    timedOut = (n >= 64);
    // released bus shows no stale address or data
    apbReq <= '0;
  endtask
endmodule // mgs_host_model

`default_nettype wire

// ### verif/module_general_status_test.sv
// self-checking bench for the module general status register block
`timescale 1ns/1ps
`default_nettype none
`include "mgs_consts.svh"

module module_general_status_test;
  localparam int NL = 2;
  localparam int HL = 2;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic coreClkEn = 1'b1;
  mgs_pkg::mgs_apb_req_t apbReq;
  mgs_pkg::mgs_apb_rsp_t apbRsp;
  logic [NL-1:0][`MGS_REG_W-1:0] netLaneStatus = '0;
  logic [HL-1:0] hostTxLockLoss = '0;
  logic refClkLoss = 1'b0;
  logic txJitterPllUnlock = 1'b0;
  logic txClockMultiplierUnlock = 1'b0;
  logic [15:0] modulePower = 16'h0000;
  logic [2:0] alarmPins;
  int errors = 0;
  int cmp_count = 0;
  logic [15:0] srcBit [7] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010,
                              16'h0400, 16'h0200, 16'h0100};

  always #12.5 core_clk = ~core_clk;

  mgs_general_status #(.NET_LANES(NL), .HOST_LANES(HL)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .coreClkEn(coreClkEn),
    .apbReq(apbReq), .apbRsp(apbRsp), .netLaneStatus(netLaneStatus),
    .hostTxLockLoss(hostTxLockLoss), .refClkLoss(refClkLoss),
    .txJitterPllUnlock(txJitterPllUnlock),
    .txClockMultiplierUnlock(txClockMultiplierUnlock),
    .modulePower(modulePower), .alarmPins(alarmPins));

  mgs_host_model u_host (.core_clk(core_clk), .apbReq(apbReq), .apbRsp(apbRsp));

  // ==========================================================
  // comparison and bus helpers
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic access(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] d, output logic e);
    logic t;
    u_host.xfer(w, idx, wd, d, e, t);
    if (t) begin
      errors++;
      $display("ERROR apb pready expected 1 seen none");
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp, input string name);
    logic [31:0] d;
    logic e;
    access(1'b0, idx, 32'h0, d, e);
    check_flag({name, " slverr"}, 1'b0, e);
    check_word(name, {16'h0000, exp}, d);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] val);
    logic [31:0] d;
    logic e;
    access(1'b1, idx, {16'h0000, val}, d, e);
    check_flag("write slverr", 1'b0, e);
  endtask

  // status after 1 edge, latch and alarm pins after 2
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask

  task automatic drive_src(input int k, input logic v);
    case (k)
      0: netLaneStatus[0][7] <= v;
      1: hostTxLockLoss[1] <= v;
      2: netLaneStatus[1][4] <= v;
      3: netLaneStatus[1][3] <= v;
      4: refClkLoss <= v;
      5: txJitterPllUnlock <= v;
      default: txClockMultiplierUnlock <= v;
    endcase
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    rd(`MGS_IDX_CTRL, 16'h001c, "ctrl reset");
    rd(`MGS_IDX_COOL_CAP, 16'hffff, "cooling capacity reset");
    rd(`MGS_IDX_ALARM_SEL, 16'h0000, "alarm select reset");
    rd(`MGS_IDX_STATUS, 16'h0000, "status reset");
    rd(`MGS_IDX_LATCH, 16'h0000, "latch reset");
  endtask

  task automatic test_refused();
    logic [31:0] d;
    logic e;
    access(1'b0, 16'hb01e, 32'h0, d, e);
    check_flag("unmapped slverr", 1'b1, e);
    check_word("unmapped data", 32'h0, d);
    access(1'b0, `MGS_IDX_LANE_BASE + 16'h0002, 32'h0, d, e);
    check_flag("absent lane slverr", 1'b1, e);
    wr(`MGS_IDX_STATUS, 16'hffff);
    rd(`MGS_IDX_STATUS, 16'h0000, "status after write");
  endtask

  task automatic test_sources();
    drive_src(0, 1'b1);
    settle();
    rd(`MGS_IDX_STATUS, 16'h0000, "tx loss while disabled");
    drive_src(0, 1'b0);
    settle();
    rd(`MGS_IDX_LATCH, 16'h0000, "latch while disabled");
    wr(`MGS_IDX_CTRL, 16'h001d);
    for (int k = 0; k < 7; k++) begin
      drive_src(k, 1'b1);
      settle();
      rd(`MGS_IDX_STATUS, srcBit[k], "status on loss");
      rd(`MGS_IDX_LATCH, srcBit[k], "latch on rise");
      rd(`MGS_IDX_LATCH, 16'h0000, "latch after read");
      drive_src(k, 1'b0);
      settle();
      rd(`MGS_IDX_STATUS, 16'h0000, "status on recovery");
      rd(`MGS_IDX_LATCH, srcBit[k], "latch on fall");
    end
  endtask

  task automatic test_cooling_alarms();
    wr(`MGS_IDX_CTRL, 16'h001f);
    wr(`MGS_IDX_COOL_CAP, 16'h0100);
    wr(`MGS_IDX_ALARM_SEL, 16'h0421);
    rd(`MGS_IDX_ALARM_SEL, 16'h0421, "alarm select readback");
    modulePower <= 16'h0100;
    settle();
    rd(`MGS_IDX_STATUS, 16'h0000, "cooling at capacity");
    check_word("pins idle", 32'h0, {29'h0, alarmPins});
    modulePower <= 16'h0101;
    hostTxLockLoss[0] <= 1'b1;
    netLaneStatus[0][3] <= 1'b1;
    netLaneStatus[1][4] <= 1'b1;
    netLaneStatus[1][7] <= 1'b1;
    refClkLoss <= 1'b1;
    txJitterPllUnlock <= 1'b1;
    txClockMultiplierUnlock <= 1'b1;
    settle();
    rd(`MGS_IDX_STATUS, 16'h27f0, "all sources set");
    rd(`MGS_IDX_LANE_BASE + 16'h0001, 16'h0090, "lane one word");
    check_word("pins all set", 32'h7, {29'h0, alarmPins});
    wr(`MGS_IDX_CTRL, 16'h001d);
    settle();
    rd(`MGS_IDX_STATUS, 16'h07f0, "interlock unused");
    check_word("pins without cooling", 32'h3, {29'h0, alarmPins});
    rd(`MGS_IDX_LATCH, 16'h27f0, "latch all set");
  endtask

  // a frozen block must not pass a source change to its pins
  task automatic test_freeze();
    coreClkEn <= 1'b0;
    hostTxLockLoss[0] <= 1'b0;
    repeat (4) @(posedge core_clk);
    check_word("pins while frozen", 32'h3, {29'h0, alarmPins});
    coreClkEn <= 1'b1;
    settle();
    check_word("pins after thaw", 32'h2, {29'h0, alarmPins});
    rd(`MGS_IDX_STATUS, 16'h07b0, "status after thaw");
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    test_reset();
    test_refused();
    test_sources();
    test_cooling_alarms();
    test_freeze();
    final_report();
  end

  // the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    final_report();
  end
endmodule // module_general_status_test

`default_nettype wire
